/* File: core/rsps_pkg.sv */
// constants, field positions and state encoding of the ramp/soak profile sequencer
package rsps_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SEG_UNIT_MS = 1000;
  localparam int SEG_UNIT_CYCLES = SEG_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  // sizes
  localparam int NUM_PROF = 7;
  localparam int NUM_SEG = 7;
  localparam int MAX_CHAIN_SEGS = NUM_PROF * NUM_SEG;
  localparam int NUM_ALARM = 4;
  localparam int DATA_W = 16;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] NO_PROFILE = 3'h0;
  localparam logic [SEL_W-1:0] LAST_SEG = 3'h6;
  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_TOL = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_EVCFG = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
  // profile words at 0x040 + 4*p, segment words at 0x400 + 64*p + 8*s + 4*w
  localparam logic [6:0] PROF_PAGE = 7'h02;
  localparam int PROF_PAGE_LSB = 5;
  localparam int PROF_P_LSB = 2;
  localparam logic [2:0] SEG_PAGE = 3'h2;
  localparam int SEG_PAGE_LSB = 9;
  localparam int SEG_P_LSB = 6;
  localparam int SEG_S_LSB = 3;
  localparam int SEG_W_BIT = 2;
  // field positions
  localparam int FIRST_SP_LSB = 16;
  localparam int EV_MASK_LSB = 16;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PAUSE_BIT = 2;
  localparam int ST_PWR_BIT = 3;
  localparam int ST_PROF_LSB = 4;
  localparam int ST_SEG_LSB = 8;
  localparam int ST_SP_LSB = 16;
  // sequencer states, gray along idle, wait, run, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_RUN = 2'h3,
    ST_DONE = 2'h2
  } rsps_state_e;
endpackage : rsps_pkg

/* File: core/rsps_ramp_if.sv */
// interface between the sequencer and its linear ramp calculator
`timescale 1ns/1ps
interface rsps_ramp_if;
  logic signed [15:0] start_val;
  logic signed [15:0] target_val;
  logic [15:0] elapsed;
  logic [15:0] duration;
  logic signed [15:0] ramp_val;
  modport calc (input start_val, input target_val, input elapsed, input duration,
                output ramp_val);
  modport user (output start_val, output target_val, output elapsed, output duration,
                input ramp_val);
endinterface : rsps_ramp_if

/* File: core/rsps_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module rsps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsps_sync_s;
  rsps_sync_s st_reg;
  rsps_sync_s st_next;
  if (W < 1) begin : g_chk
    $error("rsps_sync width must be at least 1");
  end
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_out = st_reg.s2;
endmodule : rsps_sync

/* File: core/rsps_ramp.sv */
// linear interpolation from segment start value to segment target
`timescale 1ns/1ps
module rsps_ramp (
  // ramp operands and result
  rsps_ramp_if.calc rif
);
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] quot;
  always_comb begin
    diff = 17'(rif.target_val) - 17'(rif.start_val);
    prod = 34'(diff) * $signed({18'h00000, rif.elapsed});
    if (rif.duration == 16'h0000) begin
      quot = '0;
    end else begin
      quot = prod / $signed({18'h00000, rif.duration});
    end
    rif.ramp_val = 16'(rif.start_val + $signed(quot[15:0]));
  end
endmodule : rsps_ramp

/* File: core/rsps_seq.sv */
// setpoint profile sequencer with apb register file and profile store
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module rsps_seq #(
  parameter int TICK_CYCLES = rsps_pkg::SEG_UNIT_CYCLES,
  parameter int NUM_ALARM = rsps_pkg::NUM_ALARM
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rsps_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // process side
  input wire logic signed [15:0] pv_in,
  input wire logic power_fail_in,
  // control loop side
  output logic signed [15:0] setpoint_out,
  output logic setpoint_valid_out,
  output logic paused_out,
  output logic [NUM_ALARM-1:0] event_alarm_out
);
  localparam int NP = rsps_pkg::NUM_PROF;
  localparam int NS = rsps_pkg::NUM_SEG;

  if (TICK_CYCLES < 1 || NUM_ALARM < 1 || NUM_ALARM > 16) begin : g_chk
    $error("rsps_seq parameters out of range");
  end

  typedef struct packed {
    rsps_pkg::rsps_state_e state;
    logic [2:0] sel;
    logic [2:0] prof;
    logic [2:0] seg;
    logic [15:0] tol;
    logic [15:0] count;
    logic [31:0] presc;
    logic signed [15:0] seg_start;
    logic signed [15:0] sp;
    logic [NUM_ALARM-1:0] evfunc;
    logic [NUM_ALARM-1:0] ev;
    logic pwr_d;
    logic pslverr;
    logic [31:0] prdata;
    logic [NP-1:0][2:0] link;
    logic [NP-1:0][15:0] first;
    logic [NP-1:0][NS-1:0][15:0] tgt;
    logic [NP-1:0][NS-1:0][15:0] tim;
    logic [NP-1:0][NS-1:0][NUM_ALARM-1:0] mask;
  } rsps_main_s;

  rsps_main_s st_reg;
  rsps_main_s st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and ramp calculator

  logic signed [15:0] pv_s;
  logic pwr_s;
  logic [16:0] sync_q;

  rsps_sync #(.W(17)) u_sync (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .d_in({power_fail_in, pv_in}),
    .q_out(sync_q)
  );
  assign pwr_s = sync_q[16];
  assign pv_s = $signed(sync_q[15:0]);

  rsps_ramp_if rif ();
  rsps_ramp u_ramp (
    .rif(rif.calc)
  );

  logic [15:0] cur_time;
  logic signed [15:0] cur_tgt;
  logic [2:0] cur_link;
  logic tick;
  logic paused;
  logic seg_last_tick;
  logic end_now;
  logic [NUM_ALARM-1:0] ev_next;

  function automatic logic rsps_outside(input logic signed [15:0] pv,
                                        input logic signed [15:0] sp,
                                        input logic [15:0] tol);
    logic signed [16:0] d;
    d = 17'(pv) - 17'(sp);
    if (d < 0) begin
      d = -d;
    end
    return (tol != 16'h0000) && ($unsigned(d) > {1'b0, tol});
  endfunction : rsps_outside

  assign cur_time = st_reg.tim[st_reg.prof][st_reg.seg];
  assign cur_tgt = $signed(st_reg.tgt[st_reg.prof][st_reg.seg]);
  assign cur_link = st_reg.link[st_reg.prof];
  assign tick = (st_reg.presc == 32'(TICK_CYCLES - 1));
  assign paused = (st_reg.state == rsps_pkg::ST_RUN) &&
                  rsps_outside(pv_s, st_reg.sp, st_reg.tol);
  assign seg_last_tick = tick && (16'(st_reg.count + 16'h0001) == cur_time);
  // profile ends on a zero-time segment or when its last segment expires
  assign end_now = (st_reg.state == rsps_pkg::ST_RUN) && !pwr_s && !st_reg.pwr_d &&
                   ((cur_time == 16'h0000) ||
                    (!paused && seg_last_tick && st_reg.seg == rsps_pkg::LAST_SEG));

  assign rif.start_val = st_reg.seg_start;
  assign rif.target_val = cur_tgt;
  assign rif.elapsed = st_reg.count;
  assign rif.duration = cur_time;

  // event masks gated by each alarm's function setting
  for (genvar i = 0; i < NUM_ALARM; i++) begin : g_ev
    assign ev_next[i] = (st_reg.state == rsps_pkg::ST_RUN) && st_reg.evfunc[i] &&
                        st_reg.mask[st_reg.prof][st_reg.seg][i];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic rd_hit;
  logic [31:0] rd_word;
  logic [2:0] a_p;
  logic [2:0] a_s;

  assign a_p = paddr_in[rsps_pkg::SEG_P_LSB +: 3];
  assign a_s = paddr_in[rsps_pkg::SEG_S_LSB +: 3];

  function automatic logic rsps_is_seg(input logic [rsps_pkg::ADDR_W-1:0] a);
    return (a[rsps_pkg::ADDR_W-1:rsps_pkg::SEG_PAGE_LSB] == rsps_pkg::SEG_PAGE) &&
           (a[rsps_pkg::SEG_P_LSB +: 3] < 3'(NP)) && (a[rsps_pkg::SEG_S_LSB +: 3] < 3'(NS));
  endfunction : rsps_is_seg

  function automatic logic rsps_is_prof(input logic [rsps_pkg::ADDR_W-1:0] a);
    return (a[rsps_pkg::ADDR_W-1:rsps_pkg::PROF_PAGE_LSB] == rsps_pkg::PROF_PAGE) &&
           (a[rsps_pkg::PROF_P_LSB +: 3] < 3'(NP)) && (a[1:0] == 2'h0);
  endfunction : rsps_is_prof

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    if (rsps_is_seg(paddr_in) && paddr_in[1:0] == 2'h0) begin
      if (paddr_in[rsps_pkg::SEG_W_BIT]) begin
        rd_word[15:0] = st_reg.tim[a_p][a_s];
      end else begin
        rd_word[15:0] = st_reg.tgt[a_p][a_s];
        rd_word[rsps_pkg::EV_MASK_LSB +: NUM_ALARM] = st_reg.mask[a_p][a_s];
      end
    end else if (rsps_is_prof(paddr_in)) begin
      rd_word[2:0] = st_reg.link[paddr_in[rsps_pkg::PROF_P_LSB +: 3]];
      rd_word[rsps_pkg::FIRST_SP_LSB +: 16] = st_reg.first[paddr_in[rsps_pkg::PROF_P_LSB +: 3]];
    end else begin
      case (paddr_in)
        rsps_pkg::ADDR_CTRL: begin
          rd_word[2:0] = st_reg.sel;
        end
        rsps_pkg::ADDR_TOL: begin
          rd_word[15:0] = st_reg.tol;
        end
        rsps_pkg::ADDR_EVCFG: begin
          rd_word[NUM_ALARM-1:0] = st_reg.evfunc;
        end
        rsps_pkg::ADDR_STATUS: begin
          rd_word[rsps_pkg::ST_STATE_LSB +: 2] = st_reg.state;
          rd_word[rsps_pkg::ST_PAUSE_BIT] = paused;
          rd_word[rsps_pkg::ST_PWR_BIT] = pwr_s;
          rd_word[rsps_pkg::ST_PROF_LSB +: 3] = st_reg.prof;
          rd_word[rsps_pkg::ST_SEG_LSB +: 3] = st_reg.seg;
          rd_word[rsps_pkg::ST_SP_LSB +: 16] = st_reg.sp;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.pwr_d = pwr_s;
    st_next.ev = ev_next;
    case (st_reg.state)
      rsps_pkg::ST_IDLE: begin
        if (st_reg.sel != rsps_pkg::NO_PROFILE) begin
          st_next.prof = 3'(st_reg.sel - 3'h1);
          st_next.state = rsps_pkg::ST_WAIT;
        end
      end
      rsps_pkg::ST_WAIT: begin
        st_next.sp = $signed(st_reg.first[st_reg.prof]);
        if (!pwr_s && !rsps_outside(pv_s, $signed(st_reg.first[st_reg.prof]), st_reg.tol)) begin
          st_next.state = rsps_pkg::ST_RUN;
          st_next.seg = '0;
          st_next.count = '0;
          st_next.presc = '0;
          st_next.seg_start = $signed(st_reg.first[st_reg.prof]);
        end
      end
      rsps_pkg::ST_RUN: begin
        st_next.sp = rif.ramp_val;
        if (pwr_s) begin
          st_next.presc = st_reg.presc;
        end else if (st_reg.pwr_d) begin
          st_next.count = '0;
          st_next.presc = '0;
        end else if (end_now) begin
          // an expired segment ends on its target, a zero-time one on the previous target
          st_next.seg_start = (cur_time == 16'h0000) ? st_reg.seg_start : cur_tgt;
          if (cur_link == rsps_pkg::NO_PROFILE) begin
            st_next.state = rsps_pkg::ST_DONE;
          end else begin
            st_next.prof = 3'(cur_link - 3'h1);
            st_next.seg = '0;
            st_next.count = '0;
            st_next.presc = '0;
          end
        end else if (!paused) begin
          st_next.presc = tick ? '0 : 32'(st_reg.presc + 32'h00000001);
          if (seg_last_tick) begin
            st_next.seg = 3'(st_reg.seg + 3'h1);
            st_next.count = '0;
            st_next.seg_start = cur_tgt;
          end else if (tick) begin
            st_next.count = 16'(st_reg.count + 16'h0001);
          end
        end
      end
      rsps_pkg::ST_DONE: begin
        st_next.sp = st_reg.seg_start;
      end
      default: begin
        st_next.state = rsps_pkg::ST_IDLE;
      end
    endcase
    if (st_reg.sel == rsps_pkg::NO_PROFILE) begin
      st_next.state = rsps_pkg::ST_IDLE;
    end
    // apb: read data latched at setup, write taken in access phase
    if (psel_in && !penable_in) begin
      st_next.prdata = rd_word;
      st_next.pslverr = !rd_hit;
    end
    if (psel_in && penable_in && pwrite_in) begin
      if (rsps_is_seg(paddr_in) && paddr_in[1:0] == 2'h0) begin
        if (paddr_in[rsps_pkg::SEG_W_BIT]) begin
          st_next.tim[a_p][a_s] = pwdata_in[15:0];
        end else begin
          st_next.tgt[a_p][a_s] = pwdata_in[15:0];
          st_next.mask[a_p][a_s] = pwdata_in[rsps_pkg::EV_MASK_LSB +: NUM_ALARM];
        end
      end else if (rsps_is_prof(paddr_in)) begin
        st_next.link[paddr_in[rsps_pkg::PROF_P_LSB +: 3]] = pwdata_in[2:0];
        st_next.first[paddr_in[rsps_pkg::PROF_P_LSB +: 3]] =
          pwdata_in[rsps_pkg::FIRST_SP_LSB +: 16];
      end else begin
        case (paddr_in)
          rsps_pkg::ADDR_CTRL: begin
            st_next.sel = pwdata_in[2:0];
            st_next.state = rsps_pkg::ST_IDLE;
          end
          rsps_pkg::ADDR_TOL: begin
            st_next.tol = pwdata_in[15:0];
          end
          rsps_pkg::ADDR_EVCFG: begin
            st_next.evfunc = pwdata_in[NUM_ALARM-1:0];
          end
          default: begin
            st_next.tol = st_next.tol;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata_out = st_reg.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = st_reg.pslverr;
  assign setpoint_out = st_reg.sp;
  assign setpoint_valid_out = (st_reg.state != rsps_pkg::ST_IDLE);
  assign paused_out = paused;
  assign event_alarm_out = st_reg.ev;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_idle_no_drive: assert property (
    (st_reg.sel == rsps_pkg::NO_PROFILE) && !(psel_in && penable_in && pwrite_in)
    |=> (st_reg.state == rsps_pkg::ST_IDLE) && !setpoint_valid_out)
    else $error("setpoint driven with no profile selected");

  a_pause_freeze: assert property (
    paused && !pwr_s && !st_reg.pwr_d && !end_now && st_reg.sel != rsps_pkg::NO_PROFILE
    |=> $stable(st_reg.count) && $stable(st_reg.presc) && $stable(st_reg.seg))
    else $error("segment timing moved while paused");

  a_pause_band: assert property (
    (st_reg.state == rsps_pkg::ST_RUN) && (st_reg.tol != 16'h0000) &&
    ((pv_s - st_reg.sp > $signed({1'b0, st_reg.tol})) ||
     (st_reg.sp - pv_s > $signed({1'b0, st_reg.tol})))
    |-> paused_out)
    else $error("deviation out of band without pause");

  a_zero_tol_start: assert property (
    (st_reg.state == rsps_pkg::ST_WAIT) && (st_reg.tol == 16'h0000) && !pwr_s &&
    st_reg.sel != rsps_pkg::NO_PROFILE && !(psel_in && penable_in && pwrite_in)
    |=> (st_reg.state == rsps_pkg::ST_RUN) && (st_reg.count == 16'h0000))
    else $error("zero tolerance did not start at once");

  a_zero_time_end: assert property (
    end_now && (cur_time == 16'h0000) && (cur_link == rsps_pkg::NO_PROFILE) &&
    !(psel_in && penable_in && pwrite_in)
    |=> (st_reg.state == rsps_pkg::ST_DONE) && $stable(st_reg.seg))
    else $error("zero-time segment did not end profile");

  a_link_restart: assert property (
    end_now && (cur_link != rsps_pkg::NO_PROFILE) && !(psel_in && penable_in && pwrite_in)
    |=> (st_reg.state == rsps_pkg::ST_RUN) && (st_reg.seg == 3'h0) &&
        (st_reg.prof == 3'($past(cur_link) - 3'h1)))
    else $error("linked profile did not follow immediately");

  a_event_gate: assert property (
    ##1 (event_alarm_out == ($past(st_reg.evfunc) &
         (($past(st_reg.state) == rsps_pkg::ST_RUN) ?
          $past(st_reg.mask[st_reg.prof][st_reg.seg]) : '0))))
    else $error("event output not gated by alarm function");

  a_power_restart: assert property (
    (st_reg.state == rsps_pkg::ST_RUN) && st_reg.pwr_d && !pwr_s &&
    st_reg.sel != rsps_pkg::NO_PROFILE && !(psel_in && penable_in && pwrite_in)
    |=> (st_reg.count == 16'h0000) && $stable(st_reg.seg) ##1 (setpoint_out == st_reg.seg_start))
    else $error("segment not restarted after power return");

  a_ramp_start: assert property (
    (st_reg.state == rsps_pkg::ST_RUN) && (st_reg.count == 16'h0000) && $stable(st_reg.seg_start)
    && $stable(st_reg.seg) && $stable(st_reg.prof)
    |=> setpoint_out == $past(st_reg.seg_start))
    else $error("segment ramp does not start from previous target");
endmodule : rsps_seq

/* File: sim/rsps_plant.sv */
// process stand-in: the measured value follows the setpoint or is held where it is
`timescale 1ns/1ps
module rsps_plant (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control loop side
  input wire logic signed [15:0] setpoint_in,
  input wire logic hold_in,
  // measured value
  output logic signed [15:0] pv_out
);
  // one cycle of lag when following; hold forces a standing deviation
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pv_out <= 16'sh0000;
    end else if (!hold_in) begin
      pv_out <= setpoint_in;
    end
  end
endmodule : rsps_plant

/* File: sim/rsps_seq_tb.sv */
// self-checking bench of the profile sequencer with a process stand-in
`timescale 1ns/1ps
module rsps_seq_tb;
  localparam int TICK = 8;
  localparam int TMAX = 20000;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [rsps_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [15:0] pv;
  logic power_fail = 1'b0;
  logic hold = 1'b0;
  logic signed [15:0] sp;
  logic sp_valid;
  logic paused;
  logic [rsps_pkg::NUM_ALARM-1:0] events;
  logic [31:0] rd;
  logic err;
  logic [15:0] held;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  always #20 ref_clk_in = ~ref_clk_in;

  rsps_seq #(.TICK_CYCLES(TICK), .NUM_ALARM(rsps_pkg::NUM_ALARM)) i_dut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pv_in(pv), .power_fail_in(power_fail),
    .setpoint_out(sp), .setpoint_valid_out(sp_valid), .paused_out(paused),
    .event_alarm_out(events));

  rsps_plant i_plant (.clk_in(ref_clk_in), .nrst_in(nrst_in), .setpoint_in(sp),
    .hold_in(hold), .pv_out(pv));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1) @(posedge ref_clk_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb

  task automatic rdst(input logic [1:0] exp);
    apb(1'b0, rsps_pkg::ADDR_STATUS, 32'h00000000);
    chk({30'h00000000, rd[1:0]}, {30'h00000000, exp});
  endtask : rdst

  // waits for a setpoint value, sampling on falling edges, then realigns
  task automatic wait_sp(input logic [15:0] v, input int lim);
    n = 0;
    @(negedge ref_clk_in);
    while (sp !== v && n < lim) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({16'h0000, sp}, {16'h0000, v});
    @(posedge ref_clk_in);
  endtask : wait_sp

  function automatic logic [11:0] seg_a(input int p, input int s, input int w);
    return 12'(12'h400 + 64 * p + 8 * s + 4 * w);
  endfunction : seg_a

  function automatic logic [11:0] prof_a(input int p);
    return 12'(12'h040 + 4 * p);
  endfunction : prof_a

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == TMAX) begin
      miscompares++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    rdst(2'h0);
    chk({31'h00000000, sp_valid}, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chk({rd[31:1], err}, 32'h00000001);
    apb(1'b1, rsps_pkg::ADDR_TOL, 32'h00001234);
    apb(1'b0, rsps_pkg::ADDR_TOL, 32'h00000000);
    chk(rd, 32'h00001234);
    $display("test registers done");
    // short profile, deviation check off while the process value is held away
    apb(1'b1, rsps_pkg::ADDR_TOL, 32'h00000000);
    apb(1'b1, rsps_pkg::ADDR_EVCFG, 32'h00000001);
    apb(1'b1, prof_a(0), 32'h00640000);
    apb(1'b1, seg_a(0, 0, 0), 32'h000100C8);
    apb(1'b1, seg_a(0, 0, 1), 32'h00000002);
    apb(1'b1, seg_a(0, 1, 0), 32'h000200FA);
    apb(1'b1, seg_a(0, 1, 1), 32'h00000001);
    apb(1'b1, seg_a(0, 3, 0), 32'h00000309);
    apb(1'b1, seg_a(0, 3, 1), 32'h00000001);
    hold <= 1'b1;
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000001);
    wait_sp(16'h0096, 40);
    @(negedge ref_clk_in);
    chk({28'h0000000, events}, 32'h00000001);
    wait_sp(16'h00C8, 20);
    repeat (2) @(negedge ref_clk_in);
    chk({28'h0000000, events}, 32'h00000000);
    wait_sp(16'h00FA, 20);
    repeat (8) @(posedge ref_clk_in);
    rdst(2'h2);
    chk({16'h0000, sp}, 32'h000000FA);
    $display("test single profile done");
    // start waits for the first setpoint, then a pause freezes the ramp
    apb(1'b1, rsps_pkg::ADDR_TOL, 32'h00000005);
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000001);
    repeat (20) @(posedge ref_clk_in);
    rdst(2'h1);
    chk({16'h0000, sp}, 32'h00000064);
    hold <= 1'b0;
    wait_sp(16'h0096, 60);
    hold <= 1'b1;
    // the process value stays behind, so the next segment step opens a standing deviation
    wait_sp(16'h00C8, 40);
    n = 0;
    while (paused !== 1'b1 && n < 30) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({31'h00000000, paused}, 32'h00000001);
    held = sp;
    repeat (3 * TICK + 4) @(negedge ref_clk_in);
    chk({16'h0000, sp}, {16'h0000, held});
    chk({31'h00000000, paused}, 32'h00000001);
    @(posedge ref_clk_in);
    hold <= 1'b0;
    wait_sp(16'h00FA, 80);
    $display("test tolerance done");
    // power interruption restarts the running segment
    apb(1'b1, rsps_pkg::ADDR_TOL, 32'h00000000);
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000001);
    wait_sp(16'h0096, 40);
    power_fail <= 1'b1;
    repeat (12) @(negedge ref_clk_in);
    chk({16'h0000, sp}, 32'h00000096);
    @(posedge ref_clk_in);
    power_fail <= 1'b0;
    wait_sp(16'h0064, 8);
    wait_sp(16'h0096, 3 * TICK);
    $display("test power fail done");
    // seven profiles chained into 49 segments, then closed into a loop
    for (int p = 0; p < 7; p++) begin
      apb(1'b1, prof_a(p), (p < 6) ? 32'(p + 2) : 32'h00000000);
      for (int s = 0; s < 7; s++) begin
        apb(1'b1, seg_a(p, s, 0), 32'(16 * p + s));
        apb(1'b1, seg_a(p, s, 1), 32'h00000001);
      end
    end
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000001);
    wait_sp(16'h0066, 49 * TICK + 40);
    chk(32'(n >= 48 * TICK && n <= 49 * TICK + 12), 32'h00000001);
    repeat (4) @(posedge ref_clk_in);
    rdst(2'h2);
    apb(1'b1, prof_a(6), 32'h00000001);
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000001);
    wait_sp(16'h0066, 49 * TICK + 40);
    wait_sp(16'h0001, 3 * TICK);
    rdst(2'h3);
    $display("test chain and loop done");
    // selection zero stops the sequencer
    apb(1'b1, rsps_pkg::ADDR_CTRL, 32'h00000000);
    repeat (2) @(negedge ref_clk_in);
    chk({31'h00000000, sp_valid}, 32'h00000000);
    @(posedge ref_clk_in);
    rdst(2'h0);
    $display("test deselect done");
    conclude();
  end
endmodule : rsps_seq_tb
